/* File: hw/pos_pkg.sv */
/*
 * Constants, command codes, field layouts and state type for the turn-on
 * sequencer with power-good supervision and turn-on timeout handling.
 * Assumes a 250 MHz ref_clk and a host that writes settings by command code.
 */
// Contract
// - Assert power-good at assert-level threshold
// - Below negate level: drop power-good, set status
// - Wait programmed milliseconds before raising output
// - Ramp output over programmed rise milliseconds
// - Timeout fault if undervoltage limit unreached
// - Zero timeout limit disables the timeout
// - Response 00 ignores fault, keeps running
// - Response 01 runs for delay, then retries
// - Response 10 disables output, then retry setting
// - Response 11 holds output off until cleared
// - Retry code 000 never restarts
// - Codes 001 to 011 allow 1-3 attempts
// - Attempts spaced by delay count times unit
// - Codes 100-110 allow 4-6, 111 unlimited
// - Delay code n selects 2^n time units
// - Time unit is the output-voltage fault unit
package pos_pkg;

   // ==========================================================================
   // Command codes
   localparam logic [7:0] CMD_PG_ASSERT  = 8'h5e;
   localparam logic [7:0] CMD_PG_NEGATE  = 8'h5f;
   localparam logic [7:0] CMD_WAIT_TIME  = 8'h60;
   localparam logic [7:0] CMD_RAMP_TIME  = 8'h61;
   localparam logic [7:0] CMD_TMO_LIMIT  = 8'h62;
   localparam logic [7:0] CMD_TMO_ACTION = 8'h63;

   // ==========================================================================
   // Reset values of the settings
   localparam logic [15:0] RST_PG_ASSERT  = 16'h0000;
   localparam logic [15:0] RST_PG_NEGATE  = 16'h0000;
   localparam logic [15:0] RST_WAIT_TIME  = 16'h0000;
   localparam logic [15:0] RST_RAMP_TIME  = 16'h0000;
   localparam logic [15:0] RST_TMO_LIMIT  = 16'h0000;
   localparam logic [7:0]  RST_TMO_ACTION = 8'h00;

   // ==========================================================================
   // Timeout action fields and codes
   localparam int          RESP_HI       = 7;
   localparam int          RESP_LO       = 6;
   localparam int          RETRY_HI      = 5;
   localparam int          RETRY_LO      = 3;
   localparam int          DLY_HI        = 2;
   localparam int          DLY_LO        = 0;
   localparam logic [1:0]  RESP_IGNORE   = 2'h0;
   localparam logic [1:0]  RESP_RUN      = 2'h1;
   localparam logic [1:0]  RESP_DISABLE  = 2'h2;
   localparam logic [1:0]  RESP_LATCH    = 2'h3;
   localparam logic [2:0]  RETRY_NONE    = 3'h0;
   localparam logic [2:0]  RETRY_FOREVER = 3'h7;

   // ==========================================================================
   // Timing
   localparam int unsigned MS_NS     = 1_000_000;          // One millisecond in ns
   localparam int unsigned CLK_NS    = 4;                  // ref_clk period in ns
   localparam int unsigned MS_CYCLES = MS_NS / CLK_NS;     // Cycles per ms
   localparam int unsigned TW        = 24;                 // Timer width in bits

   // ==========================================================================
   // Sequencer states
   typedef enum logic [2:0] {
      ST_OFF,
      ST_DELAY,
      ST_RISE,
      ST_ON,
      ST_RUN_FAULT,
      ST_RETRY_WAIT,
      ST_LATCHED
   } pos_state_e;

endpackage : pos_pkg

/* File: hw/pos_ms_timer.sv */
/*
 * Millisecond down-timer with its own prescaler; one-cycle expiry pulse.
 * Assumes load is a one-cycle request; a load restarts any running count.
 */
`timescale 1ns/10ps
module pos_ms_timer #(
   parameter int unsigned CYC_PER_MS = pos_pkg::MS_CYCLES,
   parameter int unsigned TW         = pos_pkg::TW
) (
   // Clock and reset
   input  wire logic          ref_clk,
   input  wire logic          rst,
   // Control
   input  wire logic          load,
   input  wire logic [TW-1:0] load_ms,
   // Status
   output logic               expired_q
);
   import pos_pkg::*;

   localparam int unsigned PW = $clog2(CYC_PER_MS + 1);

   logic [PW-1:0] pre_q;
   logic [TW-1:0] ms_q;
   logic          armed_q;

   // ==========================================================================
   // Prescaled count; zero ms expires on the next cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pre_q     <= '0;
         ms_q      <= '0;
         armed_q   <= 1'b0;
         expired_q <= 1'b0;
      end else if (load) begin
         pre_q     <= PW'(CYC_PER_MS - 1);
         ms_q      <= load_ms;
         armed_q   <= 1'b1;
         expired_q <= 1'b0;
      end else begin
         expired_q <= 1'b0;
         if (armed_q) begin
            if (ms_q == '0) begin
               expired_q <= 1'b1;
               armed_q   <= 1'b0;
            end else if (pre_q == '0) begin
               pre_q <= PW'(CYC_PER_MS - 1);
               ms_q  <= ms_q - 1'b1;
            end else begin
               pre_q <= pre_q - 1'b1;
            end
         end
      end
   end

endmodule : pos_ms_timer

/* File: hw/pos_cmd_regs.sv */
/*
 * Settings registers written and read by command code.
 * Assumes one-cycle write and read strobes; unknown codes read as zero.
 */
`timescale 1ns/10ps
module pos_cmd_regs (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Command port
   input  wire logic        cmd_wr,
   input  wire logic        cmd_rd,
   input  wire logic [7:0]  cmd_code,
   input  wire logic [15:0] cmd_wdata,
   output logic [15:0]      rd_data_q,
   output logic             rd_valid_q,
   // Settings
   output logic [15:0]      pg_assert_q,
   output logic [15:0]      pg_negate_q,
   output logic [15:0]      wait_time_q,
   output logic [15:0]      ramp_time_q,
   output logic [15:0]      tmo_limit_q,
   output logic [7:0]       tmo_action_q
);
   import pos_pkg::*;

   // ==========================================================================
   // Register writes
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pg_assert_q  <= RST_PG_ASSERT;
         pg_negate_q  <= RST_PG_NEGATE;
         wait_time_q  <= RST_WAIT_TIME;
         ramp_time_q  <= RST_RAMP_TIME;
         tmo_limit_q  <= RST_TMO_LIMIT;
         tmo_action_q <= RST_TMO_ACTION;
      end else if (cmd_wr) begin
         case (cmd_code)
            CMD_PG_ASSERT:  pg_assert_q  <= cmd_wdata;
            CMD_PG_NEGATE:  pg_negate_q  <= cmd_wdata;
            CMD_WAIT_TIME:  wait_time_q  <= cmd_wdata;
            CMD_RAMP_TIME:  ramp_time_q  <= cmd_wdata;
            CMD_TMO_LIMIT:  tmo_limit_q  <= cmd_wdata;
            CMD_TMO_ACTION: tmo_action_q <= cmd_wdata[7:0];
            default: ;
         endcase
      end
   end

   // ==========================================================================
   // Registered read-back
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rd_data_q  <= 16'h0000;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= cmd_rd;
         if (cmd_rd) begin
            case (cmd_code)
               CMD_PG_ASSERT:  rd_data_q <= pg_assert_q;
               CMD_PG_NEGATE:  rd_data_q <= pg_negate_q;
               CMD_WAIT_TIME:  rd_data_q <= wait_time_q;
               CMD_RAMP_TIME:  rd_data_q <= ramp_time_q;
               CMD_TMO_LIMIT:  rd_data_q <= tmo_limit_q;
               CMD_TMO_ACTION: rd_data_q <= {8'h00, tmo_action_q};
               default:        rd_data_q <= 16'h0000;
            endcase
         end
      end
   end

endmodule : pos_cmd_regs

/* File: hw/pos_seq_top.sv */
/*
 * Turn-on sequencer: wait time, ramp, power-good supervision, turn-on
 * timeout with ignore, run-then-retry, disable-and-retry and latch-off.
 * Assumes vout_level and uv_fault_limit share the output-voltage coding and
 * that all inputs are synchronous to ref_clk.
 */
`timescale 1ns/10ps
module pos_seq_top #(
   parameter int unsigned CYC_PER_MS = pos_pkg::MS_CYCLES
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Command port
   input  wire logic        cmd_wr,
   input  wire logic        cmd_rd,
   input  wire logic [7:0]  cmd_code,
   input  wire logic [15:0] cmd_wdata,
   output logic [15:0]      rd_data_q,
   output logic             rd_valid_q,
   // Control and measurement
   input  wire logic        turn_on_req,
   input  wire logic [15:0] vout_level,
   input  wire logic [15:0] uv_fault_limit,
   input  wire logic [15:0] vout_fault_unit_ms,
   input  wire logic        pg_pin_enable,
   input  wire logic        clear_faults,
   input  wire logic        clear_fault_bit,
   // Status outputs
   output logic             output_enable_q,
   output logic             ramp_active_q,
   output logic             output_ok_signal_q,
   output logic             pg_status_q,
   output logic             ton_fault_q,
   output logic [2:0]       attempts_q
);
   import pos_pkg::*;

   // ==========================================================================
   // Declarations
   logic [15:0]   pg_assert;
   logic [15:0]   pg_negate;
   logic [15:0]   wait_time;
   logic [15:0]   ramp_time;
   logic [15:0]   tmo_limit;
   logic [7:0]    tmo_action;
   logic [1:0]    resp;
   logic [2:0]    retry_code;
   logic [2:0]    dly_code;
   pos_state_e    state_q;
   pos_state_e    state_d;
   logic          seq_load;
   logic [TW-1:0] seq_val;
   logic          seq_done;
   logic          tmo_load;
   logic          tmo_done;
   logic          tmo_live_q;
   logic          reached;
   logic          fault_evt;
   logic          fault_clr;
   logic          att_inc;
   logic          on_d;

   // ==========================================================================
   // Helper functions
   // Delay code n counts 2^n time units
   function automatic logic [TW-1:0] unit_delay(input logic [15:0] unit_ms, input logic [2:0] code);
      unit_delay = TW'(unit_ms) << code;
   endfunction : unit_delay

   // Restart if attempts remain, otherwise stay off
   function automatic pos_state_e retry_pick(input logic [2:0] code, input logic [2:0] done_cnt);
      if (code == RETRY_NONE) begin
         retry_pick = ST_LATCHED;
      end else if (code == RETRY_FOREVER) begin
         retry_pick = ST_RETRY_WAIT;
      end else if (done_cnt < code) begin
         retry_pick = ST_RETRY_WAIT;
      end else begin
         retry_pick = ST_LATCHED;
      end
   endfunction : retry_pick

   // ==========================================================================
   // Settings registers
   pos_cmd_regs u_regs (
      .ref_clk      (ref_clk),
      .rst          (rst),
      .cmd_wr       (cmd_wr),
      .cmd_rd       (cmd_rd),
      .cmd_code     (cmd_code),
      .cmd_wdata    (cmd_wdata),
      .rd_data_q    (rd_data_q),
      .rd_valid_q   (rd_valid_q),
      .pg_assert_q  (pg_assert),
      .pg_negate_q  (pg_negate),
      .wait_time_q  (wait_time),
      .ramp_time_q  (ramp_time),
      .tmo_limit_q  (tmo_limit),
      .tmo_action_q (tmo_action)
   );

   // Field extraction
   assign resp       = tmo_action[RESP_HI:RESP_LO];
   assign retry_code = tmo_action[RETRY_HI:RETRY_LO];
   assign dly_code   = tmo_action[DLY_HI:DLY_LO];

   // ==========================================================================
   // Timers: sequence phases and turn-on timeout
   pos_ms_timer #(.CYC_PER_MS(CYC_PER_MS), .TW(TW)) u_seq_tmr (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .load      (seq_load),
      .load_ms   (seq_val),
      .expired_q (seq_done)
   );

   pos_ms_timer #(.CYC_PER_MS(CYC_PER_MS), .TW(TW)) u_tmo_tmr (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .load      (tmo_load),
      .load_ms   (TW'(tmo_limit)),
      .expired_q (tmo_done)
   );

   // Fault detection and clearing
   assign reached   = (vout_level >= uv_fault_limit);
   assign fault_evt = tmo_done && tmo_live_q && !reached;
   assign fault_clr = clear_faults || clear_fault_bit || !turn_on_req;

   // ==========================================================================
   // Next state and timer loads
   always_comb begin
      state_d  = state_q;
      seq_load = 1'b0;
      seq_val  = '0;
      tmo_load = 1'b0;
      unique case (state_q)
         ST_OFF: begin
            if (turn_on_req) state_d = ST_DELAY;
         end
         ST_DELAY: begin
            if (seq_done) state_d = ST_RISE;
         end
         ST_RISE: begin
            if (seq_done) state_d = ST_ON;
         end
         ST_ON: ;
         ST_RUN_FAULT: begin
            if (seq_done) state_d = reached ? ST_ON : retry_pick(retry_code, attempts_q);
         end
         ST_RETRY_WAIT: begin
            if (seq_done) state_d = ST_DELAY;
         end
         ST_LATCHED: begin
            if (!ton_fault_q) state_d = ST_OFF;
         end
      endcase
      // Timeout response while starting or running
      if (fault_evt && (state_q == ST_DELAY || state_q == ST_RISE || state_q == ST_ON)) begin
         unique case (resp)
            RESP_IGNORE:  state_d = state_q;
            RESP_RUN:     state_d = ST_RUN_FAULT;
            RESP_DISABLE: state_d = retry_pick(retry_code, attempts_q);
            RESP_LATCH:   state_d = ST_LATCHED;
         endcase
      end
      // Commanded off wins over everything
      if (!turn_on_req) state_d = ST_OFF;
      // Timer loads on entry to each timed state
      if (state_d != state_q) begin
         unique case (state_d)
            ST_DELAY: begin
               seq_load = 1'b1;
               seq_val  = TW'(wait_time);
               tmo_load = 1'b1;
            end
            ST_RISE: begin
               seq_load = 1'b1;
               seq_val  = TW'(ramp_time);
            end
            ST_RUN_FAULT, ST_RETRY_WAIT: begin
               seq_load = 1'b1;
               seq_val  = unit_delay(vout_fault_unit_ms, dly_code);
            end
            default: ;
         endcase
      end
   end

   // Retry counting and output enable
   assign att_inc = (state_d == ST_RETRY_WAIT) && (state_q != ST_RETRY_WAIT);
   assign on_d    = (state_d == ST_RISE) || (state_d == ST_ON) || (state_d == ST_RUN_FAULT);

   // ==========================================================================
   // State register
   always_ff @(posedge ref_clk) begin
      if (rst) state_q <= ST_OFF;
      else     state_q <= state_d;
   end

   // Sequencer outputs
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         output_enable_q <= 1'b0;
         ramp_active_q   <= 1'b0;
      end else begin
         output_enable_q <= on_d;
         ramp_active_q   <= (state_d == ST_RISE);
      end
   end

   // Timeout armed only for a nonzero limit until the level is reached
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tmo_live_q <= 1'b0;
      end else if (tmo_load) begin
         tmo_live_q <= (tmo_limit != 16'h0000);
      end else if (reached || fault_evt || !turn_on_req) begin
         tmo_live_q <= 1'b0;
      end
   end

   // Sticky timeout fault; set wins over clear
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ton_fault_q <= 1'b0;
      end else if (fault_evt) begin
         ton_fault_q <= 1'b1;
      end else if (fault_clr) begin
         ton_fault_q <= 1'b0;
      end
   end

   // Attempt counter, restored on clear
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         attempts_q <= 3'h0;
      end else if (att_inc) begin
         if (fault_clr)                     attempts_q <= 3'h1;
         else if (attempts_q != RETRY_FOREVER) attempts_q <= attempts_q + 1'b1;
      end else if (fault_clr) begin
         attempts_q <= 3'h0;
      end
   end

   // ==========================================================================
   // Power-good pin and status bit
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         output_ok_signal_q <= 1'b0;
      end else if (!pg_pin_enable || !output_enable_q || vout_level < pg_negate) begin
         output_ok_signal_q <= 1'b0;
      end else if (vout_level >= pg_assert) begin
         output_ok_signal_q <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pg_status_q <= 1'b0;
      end else if (output_enable_q && vout_level < pg_negate) begin
         pg_status_q <= 1'b1;
      end else if (clear_faults || clear_fault_bit) begin
         pg_status_q <= 1'b0;
      end
   end

   // ==========================================================================
   // Assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence fault_seen_s;
      fault_evt && turn_on_req && (state_q == ST_ON);
   endsequence

   sequence output_dropped_s;
      !output_enable_q && !ramp_active_q;
   endsequence

   pg_assert_a: assert property (pg_pin_enable && output_enable_q && vout_level >= pg_assert
         && vout_level >= pg_negate |=> output_ok_signal_q)
      else $error("power-good not asserted at threshold");

   pg_negate_a: assert property (output_enable_q && vout_level < pg_negate
         |=> !output_ok_signal_q && pg_status_q)
      else $error("power-good not negated below threshold");

   wait_hold_a: assert property (state_q == ST_DELAY && !seq_done && turn_on_req && !fault_evt
         |=> !output_enable_q && state_q == ST_DELAY)
      else $error("output raised before wait time");

   ramp_end_a: assert property (state_q == ST_RISE && seq_done && turn_on_req && !fault_evt
         |=> state_q == ST_ON ##0 !ramp_active_q ##0 output_enable_q)
      else $error("ramp did not end on time");

   tmo_flag_a: assert property (fault_evt |=> ton_fault_q)
      else $error("timeout fault not flagged");

   tmo_off_a: assert property (tmo_load && tmo_limit == 16'h0000 |=> !tmo_live_q [*2])
      else $error("zero limit armed the timeout");

   ignore_a: assert property (fault_seen_s and (resp == RESP_IGNORE) |=> state_q == ST_ON && output_enable_q)
      else $error("ignored fault interrupted output");

   run_fault_a: assert property (fault_seen_s and (resp == RESP_RUN)
         |=> state_q == ST_RUN_FAULT && output_enable_q)
      else $error("run-on response did not keep output");

   disable_a: assert property (fault_seen_s and (resp == RESP_DISABLE) |=> output_dropped_s)
      else $error("disable response left output on");

   latch_hold_a: assert property (state_q == ST_LATCHED && ton_fault_q && !fault_clr
         |=> state_q == ST_LATCHED && !output_enable_q)
      else $error("latched fault released without clear");

   no_retry_a: assert property (fault_seen_s and (resp == RESP_DISABLE) and (retry_code == RETRY_NONE)
         |=> state_q == ST_LATCHED)
      else $error("restart made with retries off");

   retry_cap_a: assert property (att_inc && !fault_clr
         |-> retry_code == RETRY_FOREVER || attempts_q < retry_code)
      else $error("restart beyond allowed attempts");

   spacing_a: assert property (state_q == ST_RETRY_WAIT && !seq_done && turn_on_req
         |=> (state_q == ST_RETRY_WAIT) and output_dropped_s)
      else $error("restart before spacing elapsed");

   count_reset_a: assert property (fault_clr && !att_inc |=> attempts_q == 3'h0)
      else $error("attempt count kept after clear");

endmodule : pos_seq_top

/* File: bench/pos_host_model.sv */
/*
 * Host model: writes and reads settings by command code, pulses clear_fault_bit.
 * Assumes the one-cycle strobe timing of the pos_seq_top command port.
 */
`timescale 1ns/10ps
module pos_host_model (
   // Clock
   input  wire logic        ref_clk,
   // Command port
   output logic             cmd_wr,
   output logic             cmd_rd,
   output logic [7:0]       cmd_code,
   output logic [15:0]      cmd_wdata,
   input  wire logic [15:0] rd_data_q,
   input  wire logic        rd_valid_q,
   // Fault clears
   output logic             clear_faults,
   output logic             clear_fault_bit
);
   // Idle levels from time zero
   initial begin
      {cmd_wr, cmd_rd, clear_faults, clear_fault_bit} = 4'h0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
   end

   // One-cycle write; data inverted once released
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(negedge ref_clk);
      cmd_code = c;
      cmd_wdata = d;
      cmd_wr = 1'b1;
      @(negedge ref_clk);
      cmd_wr = 1'b0;
      cmd_wdata = ~d;
   endtask : wr

   // One-cycle read; answer taken one cycle later
   task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic v);
      @(negedge ref_clk);
      cmd_code = c;
      cmd_rd = 1'b1;
      @(negedge ref_clk);
      cmd_rd = 1'b0;
      d = rd_data_q;
      v = rd_valid_q;
   endtask : rd

   // Clear of the timeout fault bit
   task automatic clr();
      @(negedge ref_clk);
      clear_fault_bit = 1'b1;
      @(negedge ref_clk);
      clear_fault_bit = 1'b0;
   endtask : clr
endmodule : pos_host_model

/* File: bench/tb_top.sv */
/*
 * Bench top: settings, turn-on timing, power-good and timeout responses.
 * Assumes pos_seq_top with CYC_PER_MS shortened to 10.
 */
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; $display("[ERR] %0t bad %h", $time, g); end end
module tb_top;
   import pos_pkg::*;
   localparam int C = 10;
   logic        ref_clk, rst, cmd_wr, cmd_rd, clear_faults, clear_fault_bit, turn_on_req, pg_pin_enable, v;
   logic [7:0]  cmd_code, c;
   logic [15:0] cmd_wdata, vout_level, uv_fault_limit, vout_fault_unit_ms, r, d;
   logic [15:0] rd_data_q;
   logic        rd_valid_q, output_enable_q, ramp_active_q, output_ok_signal_q, pg_status_q, ton_fault_q;
   logic [2:0]  attempts_q;
   int          err_count, n_compared, cyc, seed, n, w;
   logic [7:0]  acts [6] = '{8'h00, 8'h42, 8'h91, 8'h80, 8'hc0, 8'hb8};

   pos_seq_top #(.CYC_PER_MS(C)) u_pos_seq_top (.ref_clk, .rst, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata,
      .rd_data_q, .rd_valid_q, .turn_on_req, .vout_level, .uv_fault_limit, .vout_fault_unit_ms, .pg_pin_enable,
      .clear_faults, .clear_fault_bit, .output_enable_q, .ramp_active_q, .output_ok_signal_q, .pg_status_q,
      .ton_fault_q, .attempts_q);
   pos_host_model u_pos_host_model (.ref_clk, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata, .rd_data_q, .rd_valid_q,
      .clear_faults, .clear_fault_bit);

   // Expected read-back of a setting
   function automatic logic [15:0] exp_rd(input logic [7:0] k, input logic [15:0] x);
      if (k == CMD_TMO_ACTION) return {8'h00, x[7:0]};
      return (k > CMD_TMO_ACTION) ? 16'h0000 : x;
   endfunction : exp_rd

   // Count in range of a whole number of ms
   function automatic logic near(input int k, input int ms);
      return k >= ms * C && k <= ms * C + 8;
   endfunction : near

   // Cycles until an awaited output level, bounded
   task automatic wait_for(input int sel, output int k);
      logic hit;
      k = 0;
      hit = 1'b0;
      while (!hit && k < 3000) begin
         @(negedge ref_clk);
         k++;
         case (sel)
            0: hit = output_enable_q === 1'b1;
            1: hit = ramp_active_q === 1'b0;
            2: hit = ton_fault_q === 1'b1;
            default: hit = output_enable_q === 1'b0;
         endcase
      end
      `CHK(hit, 1'b1)
   endtask : wait_for

   // Write all six settings
   task automatic cfg(input logic [15:0] wt, input logic [15:0] lim, input logic [7:0] act);
      u_pos_host_model.wr(CMD_PG_ASSERT, 16'h1000);
      u_pos_host_model.wr(CMD_PG_NEGATE, 16'h0800);
      u_pos_host_model.wr(CMD_WAIT_TIME, wt);
      u_pos_host_model.wr(CMD_RAMP_TIME, 16'h0001);
      u_pos_host_model.wr(CMD_TMO_LIMIT, lim);
      u_pos_host_model.wr(CMD_TMO_ACTION, {8'h00, act});
   endtask : cfg

   // Let some cycles pass before a compare
   task automatic hold(input int k);
      repeat (k) @(negedge ref_clk);
   endtask : hold

   // Verdict and end of run
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize

   // Clock, 4 ns period
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // Hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         summarize();
      end
   end

   // Main sequence
   initial begin
      seed = 33;
      {turn_on_req, rst, pg_pin_enable} = 3'b011;
      vout_level = 16'h0000;
      uv_fault_limit = 16'h0c00;
      vout_fault_unit_ms = 16'h0001;
      repeat (4) @(negedge ref_clk);
      rst = 1'b0;
      @(negedge ref_clk);
      `CHK({output_enable_q, output_ok_signal_q, ton_fault_q, attempts_q}, 6'h00)
      for (int i = 0; i < 7; i++) begin
         c = 8'h5e + 8'(i);
         d = 16'($random(seed));
         u_pos_host_model.rd(c, r, v);
         `CHK(r, 16'h0000)
         u_pos_host_model.wr(c, d);
         u_pos_host_model.rd(c, r, v);
         `CHK({v, r}, {1'b1, exp_rd(c, d)})
      end
      $display("settings test done");
      w = 1 + int'($unsigned($random(seed)) % 3);
      cfg(16'(w), 16'h0000, 8'h00);
      turn_on_req = 1'b1;
      wait_for(0, n);
      `CHK(near(n, w), 1'b1)
      wait_for(1, n);
      `CHK(near(n, 1), 1'b1)
      hold(60);
      `CHK(ton_fault_q, 1'b0)
      vout_level = 16'h0fff;
      hold(4);
      `CHK(output_ok_signal_q, 1'b0)
      vout_level = 16'h1000;
      hold(4);
      `CHK(output_ok_signal_q, 1'b1)
      // Status was set during the ramp; clear it before the threshold checks
      u_pos_host_model.clr();
      vout_level = 16'h0800;
      hold(4);
      `CHK({pg_status_q, output_ok_signal_q}, 2'h1)
      vout_level = 16'h07ff;
      hold(4);
      `CHK({pg_status_q, output_ok_signal_q}, 2'h2)
      vout_level = 16'h1000;
      pg_pin_enable = 1'b0;
      hold(4);
      `CHK(output_ok_signal_q, 1'b0)
      pg_pin_enable = 1'b1;
      turn_on_req = 1'b0;
      vout_level = 16'h0000;
      $display("turn-on test done");
      foreach (acts[i]) begin
         cfg(16'h0000, 16'h0002, acts[i]);
         turn_on_req = 1'b1;
         wait_for(2, n);
         `CHK(near(n, 2), 1'b1)
         case (i)
            0: begin
               hold(20);
               `CHK(output_enable_q, 1'b1)
            end
            1: begin
               `CHK(output_enable_q, 1'b1)
               wait_for(3, n);
               `CHK(near(n, 4), 1'b1)
            end
            2: begin
               hold(2);
               `CHK(output_enable_q, 1'b0)
               wait_for(0, n);
               `CHK(near(n, 2), 1'b1)
               hold(200);
               `CHK({attempts_q, output_enable_q}, 4'h4)
            end
            3: begin
               hold(60);
               `CHK({attempts_q, output_enable_q}, 4'h0)
            end
            4: begin
               hold(40);
               `CHK(output_enable_q, 1'b0)
               u_pos_host_model.clr();
               wait_for(0, n);
               `CHK(near(n, 0), 1'b1)
            end
            default: begin
               hold(200);
               `CHK(attempts_q >= 3'd3, 1'b1)
            end
         endcase
         turn_on_req = 1'b0;
         hold(3);
         `CHK({ton_fault_q, attempts_q}, 4'h0)
         $display("response %h test done", acts[i]);
      end
      summarize();
   end
endmodule : tb_top
